// *** core/isms_pkg.sv ***
// constants, field layouts and carrier types for the i2c channel status block
// assumes a classic wishbone slave port and the i2c engines outside the block
// Behaviour
// - status bit 7 set flushes channel transmit fifo
// - slave busy bit follows slave channel activity
// - slave no-ack when remote read finds fifo empty
// - slave rx overflow set, cleared by rx read
// - slave rx irq set per byte, cleared by read
// - slave tx irq at end, cleared by tx write
// - slave tx underflow set, cleared by tx write
// - slave tx empty while fifo empty
// - master busy bit follows master channel activity
// - arbitration loss held until bus free again
// - master full fifo withholds ack, sets no-ack
// - master rx overflow set, cleared by rx read
// - master rx irq per byte, cleared by read
// - master tx irq at end, cleared by write
// - master tx empty while fifo empty
package isms_pkg;
	// register byte offsets on the wishbone port
	localparam logic [7:0] OFF_SSTA  = 8'h00;
	localparam logic [7:0] OFF_MSTA  = 8'h04;
	localparam logic [7:0] OFF_SRX   = 8'h08;
	localparam logic [7:0] OFF_STX   = 8'h0C;
	localparam logic [7:0] OFF_MRX   = 8'h10;
	localparam logic [7:0] OFF_MTX   = 8'h14;
	localparam logic [7:0] OFF_ISTAT = 8'h18;
	localparam logic [7:0] OFF_IMASK = 8'h1C;
	// fifo geometry
	localparam int         FIFO_DEPTH = 4;
	localparam int         PTR_W      = 2;
	localparam int         CNT_W      = 3;
	localparam logic [2:0] CNT_FULL   = 3'h4;
	// fifo indices
	localparam int FI_SRX = 0;
	localparam int FI_STX = 1;
	localparam int FI_MRX = 2;
	localparam int FI_MTX = 3;
	localparam int N_FIFO = 4;
	// status flag indices inside the flag vector
	localparam int FL_SBUSY  = 0;
	localparam int FL_SNOACK = 1;
	localparam int FL_SOVF   = 2;
	localparam int FL_SRXI   = 3;
	localparam int FL_STXI   = 4;
	localparam int FL_SUNF   = 5;
	localparam int FL_MBUSY  = 6;
	localparam int FL_MARB   = 7;
	localparam int FL_MNOACK = 8;
	localparam int FL_MOVF   = 9;
	localparam int FL_MRXI   = 10;
	localparam int FL_MTXI   = 11;
	localparam int N_FLAG    = 12;
	// status register bit positions
	localparam int SB_FLUSH = 7;
	// interrupt status / mask bit positions
	localparam int IB_SRX = 0;
	localparam int IB_STX = 1;
	localparam int IB_SOVF = 2;
	localparam int IB_SUNF = 3;
	localparam int IB_MRX = 4;
	localparam int IB_MTX = 5;
	localparam int IB_MOVF = 6;
	localparam int IB_MARB = 7;
	// reset values
	localparam logic [7:0]  BYTE_RST = 8'h00;
	localparam logic [31:0] WORD_RST = 32'h00000000;
	// one byte with its strobe
	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} isms_byte_t;
	// bus slave states
	typedef enum logic {WB_IDLE, WB_ACK} isms_wb_t;
endpackage

// *** core/isms_top.sv ***
// status flags, transmit/receive fifos and wishbone registers of an i2c
// slave channel and master channel; the bit engines sit outside and talk
// to this block through byte strobes and busy / arbitration levels
`timescale 1ns/1ns
module isms_top (
	input  wire logic                clk_sys_in,
	input  wire logic                resetn_in,
	input  wire logic                wb_cyc_in,
	input  wire logic                wb_stb_in,
	input  wire logic                wb_we_in,
	input  wire logic [7:0]          wb_adr_in,
	input  wire logic [3:0]          wb_sel_in,
	input  wire logic [31:0]         wb_dat_in,
	output logic      [31:0]         wb_dat_out,
	output logic                     wb_ack_out,
	output logic                     irq_out,
	input  wire logic                slv_busy_in,
	input  wire isms_pkg::isms_byte_t slv_rx_in,
	input  wire logic                slv_tx_req_in,
	output isms_pkg::isms_byte_t     slv_tx_out,
	input  wire logic                slv_tx_done_in,
	input  wire logic                mst_busy_in,
	input  wire logic                mst_arb_lost_in,
	input  wire logic                mst_bus_free_in,
	input  wire isms_pkg::isms_byte_t mst_rx_in,
	output logic                     mst_rx_ack_out,
	input  wire logic                mst_tx_req_in,
	output isms_pkg::isms_byte_t     mst_tx_out,
	input  wire logic                mst_tx_done_in
);
	// address match, shared by every decode
	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction

	isms_pkg::isms_wb_t          wb_st_r;        // bus slave state
	logic                        acc;            // new access this cycle
	logic                        rd_acc;         // read access
	logic                        wr_acc;         // write access, low lane on
	logic                        rd_srx;         // slave rx data read
	logic                        rd_mrx;         // master rx data read
	logic                        wr_stx;         // slave tx data write
	logic                        wr_mtx;         // master tx data write
	logic                        flush_s_r;      // slave tx flush control
	logic                        flush_m_r;      // master tx flush control
	logic [isms_pkg::N_FIFO-1:0] push;           // fifo write strobes
	logic [isms_pkg::N_FIFO-1:0] pop;            // fifo read strobes
	logic [isms_pkg::N_FIFO-1:0] clr;            // fifo flush
	logic [isms_pkg::N_FIFO-1:0] full;           // fifo full
	logic [isms_pkg::N_FIFO-1:0] empty;          // fifo empty
	logic [7:0]                  din  [isms_pkg::N_FIFO]; // fifo write data
	logic [7:0]                  head [isms_pkg::N_FIFO]; // fifo oldest byte
	logic [isms_pkg::N_FLAG-1:0] fl_set;         // flag set terms
	logic [isms_pkg::N_FLAG-1:0] fl_clr;         // flag clear terms
	logic [isms_pkg::N_FLAG-1:0] flag_r;         // status flags
	logic [7:0]                  ssta;           // slave status view
	logic [7:0]                  msta;           // master status view
	logic [7:0]                  ev;             // interrupt events
	logic [7:0]                  istat_r;        // sticky interrupt status
	logic [7:0]                  imask_r;        // interrupt mask

	// bus decode
	assign acc    = wb_cyc_in && wb_stb_in && (wb_st_r == isms_pkg::WB_IDLE);
	assign rd_acc = acc && !wb_we_in;
	assign wr_acc = acc && wb_we_in && wb_sel_in[0];
	assign rd_srx = rd_acc && hit(wb_adr_in, isms_pkg::OFF_SRX);
	assign rd_mrx = rd_acc && hit(wb_adr_in, isms_pkg::OFF_MRX);
	assign wr_stx = wr_acc && hit(wb_adr_in, isms_pkg::OFF_STX);
	assign wr_mtx = wr_acc && hit(wb_adr_in, isms_pkg::OFF_MTX);

	// bus slave: one wait state, ack for exactly one cycle, also when unmapped
	always_ff @(posedge clk_sys_in) begin
		if (!resetn_in) begin
			wb_st_r <= isms_pkg::WB_IDLE;
		end else begin
			case (wb_st_r)
				isms_pkg::WB_IDLE: begin
					if (acc) begin
						wb_st_r <= isms_pkg::WB_ACK;
					end
				end
				default: begin
					wb_st_r <= isms_pkg::WB_IDLE;
				end
			endcase
		end
	end
	assign wb_ack_out = (wb_st_r == isms_pkg::WB_ACK);

	// flush controls, only software owned bits of the status registers
	always_ff @(posedge clk_sys_in) begin
		if (!resetn_in) begin
			flush_s_r <= 1'b0;
			flush_m_r <= 1'b0;
		end else if (wr_acc) begin
			if (hit(wb_adr_in, isms_pkg::OFF_SSTA)) begin
				flush_s_r <= wb_dat_in[isms_pkg::SB_FLUSH];
			end else if (hit(wb_adr_in, isms_pkg::OFF_MSTA)) begin
				flush_m_r <= wb_dat_in[isms_pkg::SB_FLUSH];
			end
		end
	end

	// fifo strobes; writes while flushing or full are dropped on purpose,
	// so a full tx fifo never wraps over bytes still queued
	always_comb begin
		push[isms_pkg::FI_SRX] = slv_rx_in.valid && !full[isms_pkg::FI_SRX];
		pop[isms_pkg::FI_SRX]  = rd_srx && !empty[isms_pkg::FI_SRX];
		din[isms_pkg::FI_SRX]  = slv_rx_in.data;
		clr[isms_pkg::FI_SRX]  = 1'b0;
		push[isms_pkg::FI_STX] = wr_stx && !flush_s_r && !full[isms_pkg::FI_STX];
		pop[isms_pkg::FI_STX]  = slv_tx_req_in && !empty[isms_pkg::FI_STX];
		din[isms_pkg::FI_STX]  = wb_dat_in[7:0];
		clr[isms_pkg::FI_STX]  = flush_s_r;
		push[isms_pkg::FI_MRX] = mst_rx_in.valid && !full[isms_pkg::FI_MRX];
		pop[isms_pkg::FI_MRX]  = rd_mrx && !empty[isms_pkg::FI_MRX];
		din[isms_pkg::FI_MRX]  = mst_rx_in.data;
		clr[isms_pkg::FI_MRX]  = 1'b0;
		push[isms_pkg::FI_MTX] = wr_mtx && !flush_m_r && !full[isms_pkg::FI_MTX];
		pop[isms_pkg::FI_MTX]  = mst_tx_req_in && !empty[isms_pkg::FI_MTX];
		din[isms_pkg::FI_MTX]  = wb_dat_in[7:0];
		clr[isms_pkg::FI_MTX]  = flush_m_r;
	end

	// four byte fifos of one shape
	genvar g;
	generate
		for (g = 0; g < isms_pkg::N_FIFO; g = g + 1) begin : gen_fifo
			logic [7:0]                 mem [isms_pkg::FIFO_DEPTH]; // storage
			logic [isms_pkg::PTR_W-1:0] wp_r;   // write pointer
			logic [isms_pkg::PTR_W-1:0] rp_r;   // read pointer
			logic [isms_pkg::CNT_W-1:0] cnt_r;  // fill level
			// storage needs no reset, the count guards it
			always_ff @(posedge clk_sys_in) begin
				if (push[g]) begin
					mem[wp_r] <= din[g];
				end
			end
			// pointers and level; flush beats both strobes
			always_ff @(posedge clk_sys_in) begin
				if (!resetn_in || clr[g]) begin
					wp_r  <= '0;
					rp_r  <= '0;
					cnt_r <= '0;
				end else begin
					if (push[g]) begin
						wp_r <= wp_r + isms_pkg::PTR_W'(1);
					end
					if (pop[g]) begin
						rp_r <= rp_r + isms_pkg::PTR_W'(1);
					end
					if (push[g] && !pop[g]) begin
						cnt_r <= cnt_r + isms_pkg::CNT_W'(1);
					end else if (pop[g] && !push[g]) begin
						cnt_r <= cnt_r - isms_pkg::CNT_W'(1);
					end
				end
			end
			assign full[g]  = (cnt_r == isms_pkg::CNT_FULL);
			assign empty[g] = (cnt_r == '0);
			assign head[g]  = mem[rp_r];
		end
	endgenerate

	// flag set and clear terms; a set in the clearing cycle wins
	always_comb begin
		fl_set[isms_pkg::FL_SBUSY]  = slv_busy_in;
		fl_clr[isms_pkg::FL_SBUSY]  = !slv_busy_in;
		fl_set[isms_pkg::FL_SNOACK] = slv_tx_req_in && empty[isms_pkg::FI_STX];
		fl_clr[isms_pkg::FL_SNOACK] = !slv_busy_in;
		fl_set[isms_pkg::FL_SOVF]   = slv_rx_in.valid && full[isms_pkg::FI_SRX];
		fl_clr[isms_pkg::FL_SOVF]   = rd_srx;
		fl_set[isms_pkg::FL_SRXI]   = slv_rx_in.valid;
		fl_clr[isms_pkg::FL_SRXI]   = rd_srx;
		fl_set[isms_pkg::FL_STXI]   = slv_tx_done_in;
		fl_clr[isms_pkg::FL_STXI]   = wr_stx;
		fl_set[isms_pkg::FL_SUNF]   = slv_tx_req_in && empty[isms_pkg::FI_STX];
		fl_clr[isms_pkg::FL_SUNF]   = wr_stx;
		fl_set[isms_pkg::FL_MBUSY]  = mst_busy_in;
		fl_clr[isms_pkg::FL_MBUSY]  = !mst_busy_in;
		fl_set[isms_pkg::FL_MARB]   = mst_arb_lost_in;
		fl_clr[isms_pkg::FL_MARB]   = mst_bus_free_in;
		fl_set[isms_pkg::FL_MNOACK] = mst_rx_in.valid && full[isms_pkg::FI_MRX];
		fl_clr[isms_pkg::FL_MNOACK] = !mst_busy_in;
		fl_set[isms_pkg::FL_MOVF]   = mst_rx_in.valid && full[isms_pkg::FI_MRX];
		fl_clr[isms_pkg::FL_MOVF]   = rd_mrx;
		fl_set[isms_pkg::FL_MRXI]   = mst_rx_in.valid;
		fl_clr[isms_pkg::FL_MRXI]   = rd_mrx;
		fl_set[isms_pkg::FL_MTXI]   = mst_tx_done_in;
		fl_clr[isms_pkg::FL_MTXI]   = wr_mtx;
	end

	// flags move only on own terms
	generate
		for (g = 0; g < isms_pkg::N_FLAG; g = g + 1) begin : gen_flag
			always_ff @(posedge clk_sys_in) begin
				if (!resetn_in) begin
					flag_r[g] <= 1'b0;
				end else if (fl_set[g]) begin
					flag_r[g] <= 1'b1;
				end else if (fl_clr[g]) begin
					flag_r[g] <= 1'b0;
				end
			end
		end
	endgenerate

	// ack withheld while rx fifo full
	assign mst_rx_ack_out = !full[isms_pkg::FI_MRX];

	// status views; empty bits come straight from the fifo level
	always_comb begin
		ssta = {flush_s_r, flag_r[isms_pkg::FL_SBUSY], flag_r[isms_pkg::FL_SNOACK],
			flag_r[isms_pkg::FL_SOVF], flag_r[isms_pkg::FL_SRXI],
			flag_r[isms_pkg::FL_STXI], flag_r[isms_pkg::FL_SUNF],
			empty[isms_pkg::FI_STX]};
		msta = {flush_m_r, flag_r[isms_pkg::FL_MBUSY], flag_r[isms_pkg::FL_MARB],
			flag_r[isms_pkg::FL_MNOACK], flag_r[isms_pkg::FL_MOVF],
			flag_r[isms_pkg::FL_MRXI], flag_r[isms_pkg::FL_MTXI],
			empty[isms_pkg::FI_MTX]};
	end

	// read data, taken at the access edge; unmapped reads as zero
	always_ff @(posedge clk_sys_in) begin
		if (!resetn_in) begin
			wb_dat_out <= isms_pkg::WORD_RST;
		end else if (rd_acc) begin
			if (hit(wb_adr_in, isms_pkg::OFF_SSTA)) begin
				wb_dat_out <= {24'h000000, ssta};
			end else if (hit(wb_adr_in, isms_pkg::OFF_MSTA)) begin
				wb_dat_out <= {24'h000000, msta};
			end else if (rd_srx) begin
				wb_dat_out <= {24'h000000, empty[isms_pkg::FI_SRX] ?
					isms_pkg::BYTE_RST : head[isms_pkg::FI_SRX]};
			end else if (rd_mrx) begin
				wb_dat_out <= {24'h000000, empty[isms_pkg::FI_MRX] ?
					isms_pkg::BYTE_RST : head[isms_pkg::FI_MRX]};
			end else if (hit(wb_adr_in, isms_pkg::OFF_ISTAT)) begin
				wb_dat_out <= {24'h000000, istat_r};
			end else if (hit(wb_adr_in, isms_pkg::OFF_IMASK)) begin
				wb_dat_out <= {24'h000000, imask_r};
			end else begin
				wb_dat_out <= isms_pkg::WORD_RST;
			end
		end
	end

	// tx bytes to the engines, valid for one cycle after each request that finds the fifo not empty
	always_ff @(posedge clk_sys_in) begin
		if (!resetn_in) begin
			slv_tx_out <= '0;
			mst_tx_out <= '0;
		end else begin
			slv_tx_out.valid <= pop[isms_pkg::FI_STX];
			mst_tx_out.valid <= pop[isms_pkg::FI_MTX];
			// data stands until the next request takes a byte
			if (pop[isms_pkg::FI_STX]) begin
				slv_tx_out.data <= head[isms_pkg::FI_STX];
			end
			if (pop[isms_pkg::FI_MTX]) begin
				mst_tx_out.data <= head[isms_pkg::FI_MTX];
			end
		end
	end

	// interrupt events
	always_comb begin
		ev = '0;
		ev[isms_pkg::IB_SRX]  = fl_set[isms_pkg::FL_SRXI];
		ev[isms_pkg::IB_STX]  = fl_set[isms_pkg::FL_STXI];
		ev[isms_pkg::IB_SOVF] = fl_set[isms_pkg::FL_SOVF];
		ev[isms_pkg::IB_SUNF] = fl_set[isms_pkg::FL_SUNF];
		ev[isms_pkg::IB_MRX]  = fl_set[isms_pkg::FL_MRXI];
		ev[isms_pkg::IB_MTX]  = fl_set[isms_pkg::FL_MTXI];
		ev[isms_pkg::IB_MOVF] = fl_set[isms_pkg::FL_MOVF];
		ev[isms_pkg::IB_MARB] = fl_set[isms_pkg::FL_MARB];
	end

	// sticky status cleared by its read; an event in that cycle survives
	always_ff @(posedge clk_sys_in) begin
		if (!resetn_in) begin
			istat_r <= isms_pkg::BYTE_RST;
		end else if (rd_acc && hit(wb_adr_in, isms_pkg::OFF_ISTAT)) begin
			istat_r <= ev;
		end else begin
			istat_r <= istat_r | ev;
		end
	end

	// interrupt mask
	always_ff @(posedge clk_sys_in) begin
		if (!resetn_in) begin
			imask_r <= isms_pkg::BYTE_RST;
		end else if (wr_acc && hit(wb_adr_in, isms_pkg::OFF_IMASK)) begin
			imask_r <= wb_dat_in[7:0];
		end
	end
	assign irq_out = |(istat_r & imask_r);

	// checks
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!resetn_in);

	sequence s_acc;
		acc;
	endsequence
	sequence s_ack_pulse;
		wb_ack_out ##1 !wb_ack_out;
	endsequence
	property p_wb_ack;
		s_acc |=> s_ack_pulse;
	endproperty
	a_wb_ack: assert property (p_wb_ack) else $error("ack not one cycle after access");

	property p_flush;
		flush_s_r |=> ssta[0] && !slv_tx_out.valid;
	endproperty
	a_flush: assert property (p_flush) else $error("flushed slave fifo not empty");
	property p_sbusy;
		slv_busy_in |=> ssta[6];
	endproperty
	a_sbusy: assert property (p_sbusy) else $error("slave busy not shown");
	property p_snoack;
		slv_tx_req_in && empty[isms_pkg::FI_STX] |=> ssta[5] && !slv_tx_out.valid;
	endproperty
	a_snoack: assert property (p_snoack) else $error("slave no-ack missing");
	property p_sovf;
		slv_rx_in.valid && full[isms_pkg::FI_SRX] |=> ssta[4];
	endproperty
	a_sovf: assert property (p_sovf) else $error("slave overflow missing");
	property p_srxi;
		rd_srx && !slv_rx_in.valid |=> !ssta[3] ##1 wb_ack_out == 1'b0;
	endproperty
	a_srxi: assert property (p_srxi) else $error("slave rx irq not cleared");
	property p_stxi;
		slv_tx_done_in |=> ssta[2];
	endproperty
	a_stxi: assert property (p_stxi) else $error("slave tx irq missing");
	property p_sunf;
		wr_stx && !slv_tx_req_in |=> !ssta[1];
	endproperty
	a_sunf: assert property (p_sunf) else $error("slave underflow not cleared");
	property p_sempty;
		wr_stx && !flush_s_r |=> !ssta[0];
	endproperty
	a_sempty: assert property (p_sempty) else $error("slave empty not cleared");
	property p_mbusy;
		!mst_busy_in |=> !msta[6];
	endproperty
	a_mbusy: assert property (p_mbusy) else $error("master busy stuck");
	property p_marb;
		mst_arb_lost_in ##1 !mst_bus_free_in && !mst_arb_lost_in |=> msta[5];
	endproperty
	a_marb: assert property (p_marb) else $error("arbitration flag dropped");
	property p_mnoack;
		mst_rx_in.valid && full[isms_pkg::FI_MRX] |-> !mst_rx_ack_out ##1 msta[4];
	endproperty
	a_mnoack: assert property (p_mnoack) else $error("master full byte acked");
	property p_movf;
		rd_mrx && !mst_rx_in.valid |=> !msta[3];
	endproperty
	a_movf: assert property (p_movf) else $error("master overflow not cleared");
	property p_mrxi;
		mst_rx_in.valid |=> msta[2];
	endproperty
	a_mrxi: assert property (p_mrxi) else $error("master rx irq missing");
	property p_mtxi;
		wr_mtx && !mst_tx_done_in |=> !msta[1];
	endproperty
	a_mtxi: assert property (p_mtxi) else $error("master tx irq not cleared");
	property p_mempty;
		wr_mtx && !flush_m_r |=> !msta[0];
	endproperty
	a_mempty: assert property (p_mempty) else $error("master empty not cleared");
	property p_rdsta;
		rd_acc && hit(wb_adr_in, isms_pkg::OFF_SSTA) && (fl_set & ~flag_r) == '0
			&& (fl_clr & flag_r) == '0 |=> $stable(flag_r);
	endproperty
	a_rdsta: assert property (p_rdsta) else $error("status read changed a flag");
endmodule // isms_top

// *** tb/isms_eng_model.sv ***
// far-side model: bit engines and other bus parties, seen as byte strobes
// assumes the bench calls its tasks and that it shares the core clock
`timescale 1ns/1ns
module isms_eng_model (
	input  wire logic            clk_in,
	output logic                 slv_busy_out,
	output logic                 mst_busy_out,
	output isms_pkg::isms_byte_t slv_rx_out,
	output isms_pkg::isms_byte_t mst_rx_out,
	output logic [5:0]           ev_out
);
	// all lines idle low from time zero
	initial begin
		slv_busy_out = 1'b0;
		mst_busy_out = 1'b0;
		slv_rx_out = '0;
		mst_rx_out = '0;
		ev_out = 6'h00;
	end
	// one-cycle pulse on event line k (req, done, arb, free)
	task pulse(input int k);
		@(posedge clk_in);
		ev_out[k] <= 1'b1;
		@(posedge clk_in);
		ev_out <= 6'h00;
	endtask
	// one received byte; released data shows the inverse, not the old value
	task rx(input logic m, input logic [7:0] d);
		@(posedge clk_in);
		if (m) begin
			mst_rx_out <= '{1'b1, d};
		end else begin
			slv_rx_out <= '{1'b1, d};
		end
		@(posedge clk_in);
		mst_rx_out <= '{1'b0, ~d};
		slv_rx_out <= '{1'b0, ~d};
	endtask
	// channel activity level
	task busy(input logic m, input logic v);
		@(posedge clk_in);
		if (m) begin
			mst_busy_out <= v;
		end else begin
			slv_busy_out <= v;
		end
	endtask
endmodule // isms_eng_model

// *** tb/tb_isms_top.sv ***
// self-checking bench for the i2c channel status block
// assumes the engine model drives every engine-side input
`timescale 1ns/1ns
module tb_isms_top;
	logic                 clk_sys_in;  // core clock
	logic                 resetn_in;   // sync reset, low active
	logic                 wb_cyc;      // bus cycle
	logic                 wb_stb;      // bus strobe
	logic                 wb_we;       // write enable
	logic [7:0]           wb_adr;      // byte address
	logic [3:0]           wb_sel;      // byte lanes
	logic [31:0]          wb_dat;      // write data
	logic [31:0]          wb_rd;       // read data from dut
	logic [31:0]          wb_q;        // last read data taken
	logic                 wb_ack;      // bus answer
	logic                 irq;         // interrupt level
	logic                 rx_ack;      // master rx ack
	logic                 s_busy;      // slave busy level
	logic                 m_busy;      // master busy level
	logic [5:0]           ev;          // engine pulses
	wire                  s_req  = ev[0]; // slave read request
	wire                  s_done = ev[1]; // slave transmission end
	wire                  m_arb  = ev[2]; // arbitration lost
	wire                  m_free = ev[3]; // bus free again
	wire                  m_req  = ev[4]; // master byte request
	wire                  m_done = ev[5]; // master transmission end
	isms_pkg::isms_byte_t s_rx;        // slave rx strobe
	isms_pkg::isms_byte_t m_rx;        // master rx strobe
	isms_pkg::isms_byte_t s_tx;        // slave tx byte
	isms_pkg::isms_byte_t m_tx;        // master tx byte
	int                   errors;      // mismatches
	int                   comparisons; // checks made
	isms_top dut (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .wb_cyc_in(wb_cyc),
		.wb_stb_in(wb_stb), .wb_we_in(wb_we), .wb_adr_in(wb_adr), .wb_sel_in(wb_sel),
		.wb_dat_in(wb_dat), .wb_dat_out(wb_rd), .wb_ack_out(wb_ack), .irq_out(irq),
		.slv_busy_in(s_busy), .slv_rx_in(s_rx), .slv_tx_req_in(s_req), .slv_tx_out(s_tx),
		.slv_tx_done_in(s_done), .mst_busy_in(m_busy), .mst_arb_lost_in(m_arb),
		.mst_bus_free_in(m_free), .mst_rx_in(m_rx), .mst_rx_ack_out(rx_ack),
		.mst_tx_req_in(m_req), .mst_tx_out(m_tx), .mst_tx_done_in(m_done));
	isms_eng_model eng (.clk_in(clk_sys_in), .slv_busy_out(s_busy), .mst_busy_out(m_busy),
		.slv_rx_out(s_rx), .mst_rx_out(m_rx), .ev_out(ev));
	// 100 MHz core clock
	always #5 clk_sys_in = ~clk_sys_in;
	// one counted comparison
	task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	// classic single cycle, held until ack is sampled high
	task wb(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [3:0] s);
		int n;
		@(posedge clk_sys_in);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= w;
		wb_sel <= s;
		wb_adr <= a;
		wb_dat <= {24'h000000, d};
		n = 0;
		do begin
			@(posedge clk_sys_in);
			n++;
		end while (wb_ack !== 1'b1 && n < 50);
		wb_q = wb_rd;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		chk({31'h0, wb_ack}, 32'h1, "bus ack");
	endtask
	// register read compared with an expected byte
	task rd(input logic [7:0] a, input logic [7:0] e);
		wb(1'b0, a, 8'h00, 4'hF);
		chk(wb_q, {24'h000000, e}, "read");
	endtask
	// register write
	task wr(input logic [7:0] a, input logic [7:0] d);
		wb(1'b1, a, d, 4'hF);
	endtask
	// values after reset, writes to flag bits have no effect
	task t_reset;
		chk({31'h0, rx_ack}, 32'h1, "rx ack");
		rd(isms_pkg::OFF_SSTA, 8'h01);
		rd(isms_pkg::OFF_MSTA, 8'h01);
		wr(isms_pkg::OFF_SSTA, 8'h7F);
		rd(isms_pkg::OFF_SSTA, 8'h01);
		// low byte lane off: the flush bit must not take the write
		wb(1'b1, isms_pkg::OFF_SSTA, 8'h80, 4'h0);
		rd(isms_pkg::OFF_SSTA, 8'h01);
	endtask
	// slave transmit: data, underflow, no-ack, done, write clears
	task t_stx;
		eng.busy(1'b0, 1'b1);
		rd(isms_pkg::OFF_SSTA, 8'h41);
		wr(isms_pkg::OFF_STX, 8'hA5);
		rd(isms_pkg::OFF_SSTA, 8'h40);
		eng.pulse(0);
		@(posedge clk_sys_in);
		chk({23'h0, s_tx}, {23'h0, 1'b1, 8'hA5}, "slave tx");
		@(posedge clk_sys_in);
		chk({31'h0, s_tx.valid}, 32'h0, "slave tx end");
		eng.pulse(0);
		rd(isms_pkg::OFF_SSTA, 8'h63);
		eng.pulse(1);
		rd(isms_pkg::OFF_SSTA, 8'h67);
		rd(isms_pkg::OFF_SSTA, 8'h67);
		wr(isms_pkg::OFF_STX, 8'h3C);
		rd(isms_pkg::OFF_SSTA, 8'h60);
		eng.busy(1'b0, 1'b0);
		rd(isms_pkg::OFF_SSTA, 8'h00);
	endtask
	// flush empties a loaded tx fifo, release returns to normal
	task t_flush(input logic [7:0] o);
		wr(o, 8'h80);
		rd(o, 8'h81);
		wr(o, 8'h00);
		rd(o, 8'h01);
	endtask
	// five bytes into a four-deep slave fifo
	task t_srx;
		for (int i = 0; i < 5; i++) eng.rx(1'b0, 8'h10 + i[7:0]);
		rd(isms_pkg::OFF_SSTA, 8'h19);
		for (int i = 0; i < 4; i++) rd(isms_pkg::OFF_SRX, 8'h10 + i[7:0]);
		rd(isms_pkg::OFF_SSTA, 8'h01);
	endtask
	// master fifo full: ack withheld, no-ack and overflow
	task t_mrx;
		eng.busy(1'b1, 1'b1);
		for (int i = 0; i < 4; i++) eng.rx(1'b1, 8'h20 + i[7:0]);
		@(posedge clk_sys_in);
		chk({31'h0, rx_ack}, 32'h0, "rx ack full");
		eng.rx(1'b1, 8'h2F);
		rd(isms_pkg::OFF_MSTA, 8'h5D);
		rd(isms_pkg::OFF_MRX, 8'h20);
		chk({31'h0, rx_ack}, 32'h1, "rx ack");
		rd(isms_pkg::OFF_MSTA, 8'h51);
		eng.busy(1'b1, 1'b0);
		rd(isms_pkg::OFF_MSTA, 8'h01);
		for (int i = 1; i < 4; i++) rd(isms_pkg::OFF_MRX, 8'h20 + i[7:0]);
	endtask
	// master transmit and done flag
	task t_mtx;
		wr(isms_pkg::OFF_MTX, 8'h5A);
		wr(isms_pkg::OFF_MTX, 8'hC3);
		rd(isms_pkg::OFF_MSTA, 8'h00);
		eng.pulse(4);
		@(posedge clk_sys_in);
		chk({23'h0, m_tx}, {23'h0, 1'b1, 8'h5A}, "master tx");
		eng.pulse(5);
		rd(isms_pkg::OFF_MSTA, 8'h02);
		wr(isms_pkg::OFF_MTX, 8'h77);
		rd(isms_pkg::OFF_MSTA, 8'h00);
	endtask
	// arbitration loss held until the bus is free
	task t_arb;
		eng.pulse(2);
		rd(isms_pkg::OFF_MSTA, 8'h21);
		rd(isms_pkg::OFF_MSTA, 8'h21);
		eng.pulse(3);
		rd(isms_pkg::OFF_MSTA, 8'h01);
	endtask
	// sticky status, mask, read clear, unmapped place
	task t_irq;
		rd(isms_pkg::OFF_ISTAT, 8'hFF);
		rd(isms_pkg::OFF_ISTAT, 8'h00);
		wr(isms_pkg::OFF_IMASK, 8'h01);
		eng.pulse(2);
		repeat (2) @(posedge clk_sys_in);
		chk({31'h0, irq}, 32'h0, "irq masked");
		eng.rx(1'b0, 8'h55);
		repeat (2) @(posedge clk_sys_in);
		chk({31'h0, irq}, 32'h1, "irq");
		rd(isms_pkg::OFF_IMASK, 8'h01);
		rd(isms_pkg::OFF_ISTAT, 8'h81);
		chk({31'h0, irq}, 32'h0, "irq cleared");
		eng.pulse(3);
		rd(isms_pkg::OFF_SRX, 8'h55);
		rd(8'h20, 8'h00);
	endtask
	// verdict and end of run
	task test_done;
		$display("errors=%0d comparisons=%0d", errors, comparisons);
		if (errors == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// watchdog, far beyond the few hundred cycles the tests need
	initial begin
		repeat (5000) @(posedge clk_sys_in);
		errors++;
		test_done;
	end
	// reset, then the scenarios in order
	initial begin
		clk_sys_in = 1'b0;
		resetn_in = 1'b0;
		wb_cyc = 1'b0;
		wb_stb = 1'b0;
		wb_we = 1'b0;
		wb_adr = 8'h00;
		wb_sel = 4'hF;
		wb_dat = 32'h00000000;
		wb_q = 32'h00000000;
		errors = 0;
		comparisons = 0;
		repeat (20) @(posedge clk_sys_in);
		resetn_in <= 1'b1;
		t_reset;
		t_stx;
		t_flush(isms_pkg::OFF_SSTA);
		t_srx;
		t_mrx;
		t_mtx;
		t_flush(isms_pkg::OFF_MSTA);
		t_arb;
		t_irq;
		test_done;
	end
endmodule // tb_isms_top
